// ---- hdl/smu_defines.vh ----
`ifndef SMU_DEFINES_VH
`define SMU_DEFINES_VH

// ==========================================================
// opcode and source form encoding
`define SMU_OP_WORD     6'h19
`define SMU_OP_LONG     6'h18
`define SMU_MODE_RIM    2'h0
`define SMU_MODE_DIRX   2'h1
`define SMU_MODE_REG    2'h2

// address forms (flat, short segment, long segment)
`define SMU_FORM_FLAT   2'h0
`define SMU_FORM_SHORT  2'h1
`define SMU_FORM_LONG   2'h2

// ==========================================================
// cycle counts
`define SMU_WORD_BASE   9'h046
`define SMU_LONG_BASE   9'h11a
`define SMU_WORD_ZERO   9'h012
`define SMU_LONG_ZERO   9'h01e
`define SMU_PER_ONE     9'h007

// direct and indexed adders per address form
`define SMU_ADD_DIR_FLAT  9'h001
`define SMU_ADD_IDX_FLAT  9'h002
`define SMU_ADD_SHORT     9'h002
`define SMU_ADD_DIR_LONG  9'h004
`define SMU_ADD_IDX_LONG  9'h005

// ==========================================================
// flag vector positions: c z s v
`define SMU_FLAG_C      0
`define SMU_FLAG_Z      1
`define SMU_FLAG_S      2
`define SMU_FLAG_V      3

`endif

// ---- hdl/smu_core.v ----
`timescale 1ns/1ns
`default_nettype none
`include "smu_defines.vh"

// ==========================================================
// product and flag arithmetic, purely combinational
module smu_core (
    input  wire        long_op,     // long form selected
    input  wire [31:0] mcand,       // low part of destination
    input  wire [31:0] mplier,      // source value
    output reg  [63:0] product,     // signed product
    output reg  [3:0]  flags,       // c z s v
    output reg  [4:0]  ones         // ones in |mcand[15:0]|
);
    reg signed [63:0] a;
    reg signed [63:0] b;
    reg        [15:0] mag;
    integer           i;

    // sign extend per width so upper destination never leaks in
    always @* begin
        a = long_op ? {{32{mcand[31]}}, mcand} : {{48{mcand[15]}}, mcand[15:0]};
        b = long_op ? {{32{mplier[31]}}, mplier} : {{48{mplier[15]}}, mplier[15:0]};
        product = a * b;
        flags = 4'h0;
        if (long_op)
            flags[`SMU_FLAG_C] = (product[63:31] != {33{1'b0}}) &&
                                 (product[63:31] != {33{1'b1}});
        else
            flags[`SMU_FLAG_C] = (product[31:15] != {17{1'b0}}) &&
                                 (product[31:15] != {17{1'b1}});
        flags[`SMU_FLAG_Z] = long_op ? (product == 64'h0) : (product[31:0] == 32'h0);
        flags[`SMU_FLAG_S] = long_op ? product[63] : product[31];
        mag = mcand[15] ? (16'h0 - mcand[15:0]) : mcand[15:0];
        ones = 5'h0;
        for (i = 0; i < 16; i = i + 1)
            ones = ones + {4'h0, mag[i]};
    end
endmodule

`default_nettype wire

// ---- hdl/smu_top.v ----
// Notes on behaviour
// - word: low pair half times word source
// - long: low quad half times long source
// - operands and product are signed
// - source operand is never written
// - old upper destination ignored, overwritten
// - carry when product exceeds operand range
// - zero, sign set; overflow cleared; others kept
// - word takes 70 to 75 cycles by form
// - long takes 282+ plus seven per one
// - zero multiplier finishes in 18 or 30 plus the form adder
`timescale 1ns/1ns
`default_nettype none
`include "smu_defines.vh"

module smu_top (
    input  wire        clk,           // 10 mhz processor clock
    input  wire        rst_b,         // synchronous reset, active low
    input  wire        start,         // one-cycle issue pulse
    input  wire [5:0]  opcode,        // word_product_op / long_product_op
    input  wire [1:0]  src_mode,      // top two instruction bits
    input  wire        src_zero,      // source field is zero
    input  wire [1:0]  addr_form,     // flat_address_form, short, long_segment_form
    input  wire [3:0]  dest_field,    // dest_pair_field or dest_quad_field
    input  wire [31:0] dest_low,      // low half of destination from file
    input  wire [31:0] src_value,     // register or memory source value
    input  wire        ext_valid,     // immediate extension word strobe
    input  wire [15:0] ext_word,      // immediate extension word
    output reg         busy,          // operation in progress
    output reg         done,          // one-cycle completion pulse
    output reg  [63:0] result,        // product for write back
    output reg  [3:0]  result_dest,   // destination register number
    output reg         result_long,   // write four registers, else two
    output reg  [3:0]  flags_out,     // c z s v
    output reg  [3:0]  flags_we       // which flags are written
);
    // ======================================================
    // states
    localparam ST_IDLE = 3'h1;
    localparam ST_EXT  = 3'h2;
    localparam ST_RUN  = 3'h4;

    reg  [2:0]  state_reg;
    reg  [2:0]  state_next;
    reg         long_reg;
    reg  [31:0] mcand_reg;
    reg  [31:0] mplier_reg;
    reg  [3:0]  dest_reg;
    reg  [1:0]  mode_reg;
    reg  [1:0]  form_reg;
    reg         imm_reg;
    reg         half_reg;         // high word of long immediate taken
    reg  [8:0]  count_reg;
    wire [63:0] product;
    wire [3:0]  flags;
    wire [4:0]  ones;

    // ======================================================
    // issue decode, only looked at while idle
    wire        issue_long;       // long form opcode
    wire        issue_imm;        // immediate source, extension words follow
    wire        issue_direct;     // direct address rather than indexed
    wire [31:0] issue_mplier;     // source cut to the operand width
    wire [63:0] wb_value;         // product as written back
    wire        run_last;         // last counted cycle of a run

    // any opcode other than the long form runs as a word multiply
    assign issue_long   = (opcode == `SMU_OP_LONG);
    assign issue_imm    = (src_mode == `SMU_MODE_RIM) && src_zero;
    assign issue_direct = (src_mode == `SMU_MODE_DIRX) && src_zero;
    // a word source keeps only its low half; the source is never written
    assign issue_mplier = issue_long ? src_value : {16'h0, src_value[15:0]};

    // ======================================================
    // arithmetic
    smu_core u_core (
        .long_op (long_reg),
        .mcand   (mcand_reg),
        .mplier  (mplier_reg),
        .product (product),
        .flags   (flags),
        .ones    (ones)
    );

    // ======================================================
    // cycle budget; count includes the issue cycle
    reg [8:0] extra;
    reg [8:0] total;
    always @* begin
        extra = 9'h0;
        if (mode_reg == `SMU_MODE_DIRX) begin
            // indexed adds one over direct except the short form
            case (form_reg)
                `SMU_FORM_FLAT: begin
                    extra = imm_reg ? `SMU_ADD_DIR_FLAT : `SMU_ADD_IDX_FLAT;
                end
                `SMU_FORM_SHORT: begin
                    extra = `SMU_ADD_SHORT;
                end
                default: begin
                    // long segment form; the unused fourth code times the same
                    extra = imm_reg ? `SMU_ADD_DIR_LONG : `SMU_ADD_IDX_LONG;
                end
            endcase
        end
        // zero test uses the whole multiplier, so a word never sees stale upper bits
        if (mplier_reg == 32'h0)
            total = (long_reg ? `SMU_LONG_ZERO : `SMU_WORD_ZERO) + extra;
        // long timing depends on the multiplicand's ones, not on the multiplier
        else if (long_reg)
            total = `SMU_LONG_BASE + extra + `SMU_PER_ONE * {4'h0, ones};
        else
            total = `SMU_WORD_BASE + extra;
    end

    // ======================================================
    // end of run and write-back value
    // the compare sees the count before this edge bumps it
    assign run_last = (count_reg + 9'h1 >= total);
    // a word product leaves the upper half zero, so old contents never show
    assign wb_value = long_reg ? product : {32'h0, product[31:0]};

    // ======================================================
    // next state
    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                // an immediate waits for its extension words before counting
                if (start)
                    state_next = issue_imm ? ST_EXT : ST_RUN;
            end
            ST_EXT: begin
                // a long immediate needs both halves before it may run
                if (ext_valid && (!long_reg || half_reg))
                    state_next = ST_RUN;
            end
            ST_RUN: begin
                // the issue cycle counts as the first of the budget
                if (run_last)
                    state_next = ST_IDLE;
            end
            default: state_next = ST_IDLE;
        endcase
    end

    // ======================================================
    // datapath registers; source is latched, never written back
    always @(posedge clk) begin
        if (!rst_b) begin
            // a run cut by reset leaves no done pulse or flag write behind
            state_reg   <= ST_IDLE;
            long_reg    <= 1'b0;
            mcand_reg   <= 32'h0;
            mplier_reg  <= 32'h0;
            dest_reg    <= 4'h0;
            mode_reg    <= 2'h0;
            form_reg    <= 2'h0;
            imm_reg     <= 1'b0;
            half_reg    <= 1'b0;
            count_reg   <= 9'h0;
            busy        <= 1'b0;
            done        <= 1'b0;
            result      <= 64'h0;
            result_dest <= 4'h0;
            result_long <= 1'b0;
            flags_out   <= 4'h0;
            flags_we    <= 4'h0;
        end else begin
            state_reg <= state_next;
            done      <= 1'b0;
            flags_we  <= 4'h0;
            case (state_reg)
                ST_IDLE: begin
                    if (start) begin
                        busy      <= 1'b1;
                        long_reg  <= issue_long;
                        // only the low destination half is taken, never the upper
                        mcand_reg <= dest_low;
                        mplier_reg <= issue_mplier;
                        dest_reg  <= dest_field;
                        mode_reg  <= src_mode;
                        form_reg  <= addr_form;
                        imm_reg   <= issue_direct;      // direct, not indexed
                        half_reg  <= 1'b0;
                        count_reg <= 9'h1;
                    end
                end
                ST_EXT: begin
                    // count holds still here; fetch latency is the issuer's
                    if (ext_valid) begin
                        if (!long_reg)
                            mplier_reg <= {16'h0, ext_word};
                        else if (!half_reg)
                            mplier_reg[31:16] <= ext_word;
                        else
                            mplier_reg[15:0] <= ext_word;
                        half_reg <= 1'b1;
                    end
                end
                ST_RUN: begin
                    count_reg <= count_reg + 9'h1;
                    if (state_next == ST_IDLE) begin
                        busy        <= 1'b0;
                        done        <= 1'b1;
                        result      <= wb_value;
                        result_dest <= dest_reg;
                        result_long <= long_reg;
                        flags_out   <= flags;
                        flags_we    <= 4'hf;  // d and h untouched, not driven
                    end
                end
                // an illegal state code falls back to idle without a result
                default: busy <= 1'b0;
            endcase
        end
    end
endmodule

`default_nettype wire

// ---- sim/smu_asserts.sv ----
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// checker on the multiply unit ports
module smu_asserts (
    input wire logic        clk,         // processor clock
    input wire logic        rst_b,       // sync reset, active low
    input wire logic        start,       // issue pulse
    input wire logic        busy,        // in progress
    input wire logic        done,        // completion pulse
    input wire logic [63:0] result,      // product
    input wire logic        result_long, // long form result
    input wire logic [3:0]  flags_out,   // c z s v
    input wire logic [3:0]  flags_we     // flag write strobes
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    // issue and completion handshake
    a_start_sets_busy: assert property (start && !busy |=> busy)
        else $error("busy not raised after start");
    a_done_ends_busy: assert property (done |-> !busy)
        else $error("busy still high with done");
    a_done_one_cycle: assert property (done |=> !done)
        else $error("done longer than one cycle");
    // even the zero shortcut takes far longer than eight cycles
    a_no_early_done: assert property ($rose(busy) |-> (!done)[*8])
        else $error("done too early");
    // flags against the product at completion
    a_carry_range: assert property (done |-> flags_out[0] == (result_long ?
        (|result[63:31] && ~&result[63:31]) : (|result[31:15] && ~&result[31:15])))
        else $error("carry wrong");
    a_zero_flag: assert property (done |-> flags_out[1] == (result == 64'h0))
        else $error("zero flag wrong");
    a_sign_flag: assert property (done |->
        flags_out[2] == (result_long ? result[63] : result[31]))
        else $error("sign flag wrong");
    a_ovf_cleared: assert property (done |-> !flags_out[3] && flags_we == 4'hf)
        else $error("overflow not cleared");
    a_word_upper: assert property (done && !result_long |-> result[63:32] == 32'h0)
        else $error("word result upper half not zero");
    a_we_only_done: assert property (flags_we != 4'h0 |-> done)
        else $error("flag write without done");
endmodule
bind smu_top smu_asserts smu_asserts_i (.clk(clk), .rst_b(rst_b), .start(start),
    .busy(busy), .done(done), .result(result), .result_long(result_long),
    .flags_out(flags_out), .flags_we(flags_we));
`default_nettype wire

// ---- sim/smu_issuer.sv ----
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// instruction fetch side: hands immediate extension words over
module smu_issuer (
    input wire logic        clk,       // processor clock
    input wire logic        go,        // immediate operation issued
    input wire logic        long_op,   // two words, else one
    input wire logic [31:0] imm,       // immediate multiplier
    output logic            ext_valid, // word strobe
    output logic [15:0]     ext_word   // extension word
);
    // fetch delay of two cycles, then words back to back; one process drives both
    initial begin
        ext_valid = 1'b0;
        ext_word = 16'h0;
        forever begin
            @(posedge go);
            repeat (2) @(posedge clk);
            if (long_op) begin
                ext_valid <= 1'b1;
                ext_word <= imm[31:16];
                @(posedge clk);
            end
            ext_valid <= 1'b1;
            ext_word <= imm[15:0];
            @(posedge clk);
            ext_valid <= 1'b0;
            ext_word <= ~imm[15:0]; // stale bus shows garbage
        end
    end
endmodule
`default_nettype wire

// ---- sim/test_signed_multiply_unit.sv ----
`timescale 1ns/1ns
`default_nettype none
module test_signed_multiply_unit;
    typedef struct packed {
        bit          l;
        bit [1:0]    m;
        bit          z;
        bit [1:0]    f;
        logic [31:0] a;
        logic [31:0] b;
        int          cyc;
    } smu_row_t;
    logic clk = 0, rst_b = 0, start = 0, src_zero = 0, ext_valid, go = 0;
    logic [5:0] opcode = 6'h19;
    logic [1:0] src_mode = 2'h2, addr_form = 2'h0;
    logic [3:0] dest_field = 4'h0, result_dest, flags_out, flags_we;
    logic [31:0] dest_low = 32'h0, src_value = 32'h0;
    logic [15:0] ext_word;
    logic busy, done, result_long;
    logic [63:0] result;
    int fail_count = 0, total_checks = 0;
    // cycle budgets count the issue cycle; immediate rows add the fetch wait on top
    smu_row_t rows [13] = '{'{0,2,0,0,32'hdead0003,-5,70}, '{0,2,0,0,32'h7fff,2,70},
        '{0,2,0,0,32'hbeef1234,0,18}, '{1,2,0,0,32'h80000000,2,282}, '{1,2,0,0,-3,7,296},
        '{0,0,1,0,49,-10,70}, '{1,0,1,0,49,10,303}, '{0,1,1,2,-2,3,74},
        '{0,1,0,2,5,5,75}, '{1,1,0,2,7,0,35}, '{1,1,1,1,1,1,291},
        '{0,1,1,0,32'h8000,32'h8000,71}, '{1,0,0,0,5,-1,296}};
    smu_top smu_top_i (.clk(clk), .rst_b(rst_b), .start(start), .opcode(opcode),
        .src_mode(src_mode), .src_zero(src_zero), .addr_form(addr_form),
        .dest_field(dest_field), .dest_low(dest_low), .src_value(src_value),
        .ext_valid(ext_valid), .ext_word(ext_word), .busy(busy), .done(done),
        .result(result), .result_dest(result_dest), .result_long(result_long),
        .flags_out(flags_out), .flags_we(flags_we));
    smu_issuer smu_issuer_i (.clk(clk), .go(go), .long_op(opcode[0] == 1'b0),
        .imm(src_value), .ext_valid(ext_valid), .ext_word(ext_word));
    // ==========================================================
    // 10 mhz clock
    initial forever #50 clk = ~clk;
    task chk(input logic [63:0] got, input logic [63:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // one operation; a second start mid-run must be ignored
    task run(input smu_row_t r);
        int k;
        longint p;
        @(posedge clk);
        opcode <= r.l ? 6'h18 : 6'h19;
        src_mode <= r.m;
        src_zero <= r.z;
        addr_form <= r.f;
        dest_field <= r.l ? 4'h8 : 4'h6;
        dest_low <= r.a;
        src_value <= r.b;
        start <= 1'b1;
        go <= (r.m == 2'h0) && r.z;
        @(posedge clk);
        start <= 1'b0;
        go <= 1'b0;
        k = 0;
        while (k < 400) begin
            @(posedge clk);
            k++;
            start <= (k == 5);
            #1;
            if (k == 1) chk(busy, 1'b1);
            if (done === 1'b1) break;
        end
        if (k == 400) begin
            fail_count++;
            tally_and_finish();
        end else begin
            p = r.l ? longint'($signed(r.a)) * longint'($signed(r.b))
                    : longint'($signed(r.a[15:0])) * longint'($signed(r.b[15:0]));
            chk(result, r.l ? p : {32'h0, p[31:0]});
            chk(flags_out, {1'b0, p < 0, p == 0, r.l ? (p < -(64'sd1 <<< 31) || p >= (64'sd1 <<< 31))
                : (p < -32768 || p >= 32768)});
            chk({busy, flags_we, result_dest, result_long}, {1'b0, 4'hf, r.l ? 4'h8 : 4'h6, r.l});
            // issue cycle counts; an immediate waits out two or three fetch edges
            chk(k + 1 - ((r.m == 2'h0 && r.z) ? (r.l ? 3 : 2) : 0), r.cyc);
        end
    endtask
    // ==========================================================
    // reset, table of cases, then reset in mid-run
    initial begin
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        #1;
        chk({busy, done, result_long, result_dest, flags_out, flags_we}, 15'h0);
        chk(result, 64'h0);
        foreach (rows[i]) run(rows[i]);
        // start an operation, then pull reset one cycle into it
        @(posedge clk);
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        rst_b <= 1'b0;
        #1;
        chk(busy, 1'b1);
        @(posedge clk);
        rst_b <= 1'b1;
        #1;
        chk({busy, done, result_long, result_dest, flags_out, flags_we}, 15'h0);
        chk(result, 64'h0);
        run(rows[4]);
        tally_and_finish();
    end
endmodule
`default_nettype wire
